// ===== mnie_pkg.sv
/*
 Package for the move/idle instruction executor: opcode fields, encodings,
 register map, vector address and the control/status words.
 Assumes a 14-bit instruction word and an 8-bit data path.
*/
package mnie_pkg;
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PC_W = 13;
	// opcode field patterns
	localparam logic [5:0] OP_COPY = 6'h08; // bits 13:8 of copy_file_reg
	localparam logic [6:0] OP_STORE = 7'h01; // bits 13:7 of store_working_reg
	localparam logic [13:0] IDLE_MASK = 14'h3f9f; // x bits 6:5 ignored
	localparam logic [13:0] IDLE_CODE = 14'h0000;
	localparam int DEST_BIT = 7;
	localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
	// avalon register map, word addresses
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_INSTR = 2'h1;
	localparam logic [1:0] REG_STATUS = 2'h2;
	localparam logic [1:0] REG_WORK = 2'h3;
	localparam int CTRL_GIE = 0;
	localparam int CTRL_IRQEN = 1;
	localparam int CTRL_SLEEP = 2;
	localparam int CTRL_IRQFLAG = 3;
	localparam logic [31:0] UNMAPPED = 32'h00000000;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

	typedef enum logic [1:0] {
		MNIE_RUN,
		MNIE_SLEEP,
		MNIE_WAKE
	} mnie_state_t;

	typedef struct packed {
		logic zero;
		logic stored;
		logic copied;
		logic idled;
	} mnie_flags_t;
endpackage : mnie_pkg

// ===== mnie_file_mem.sv
/*
 128 x 8 register file with one write port and a registered read port.
 Assumes single clock, write and read in the same cycle see the old value.
*/
module mnie_file_mem #(
	parameter int DEPTH = 128,
	parameter int AW = 7,
	parameter int DW = 8
) (
	input wire logic sys_clk,
	input wire logic we,
	input wire logic [AW-1:0] wAddr,
	input wire logic [DW-1:0] wData,
	input wire logic [AW-1:0] rAddr,
	output logic [DW-1:0] rData
);
	logic [DW-1:0] mem [DEPTH];

	// no reset on the array: contents are software state
	always_ff @(posedge sys_clk) begin
		if (we) begin
			mem[wAddr] <= wData;
		end
		rData <= mem[rAddr];
	end
endmodule : mnie_file_mem

// ===== mnie_exec.sv
/*
 Executor for copy_file_reg, store_working_reg and idle_op plus the
 resume-after-sleep sequence, with an Avalon-MM slave for control.
 Assumes one 100 MHz clock; instruction issue is by a bus write.
*/
// Implementation choices: the register addresses and register access over Avalon-MM.
// How it works
// - copy moves file reg to working reg (d=0) or back to itself (d=1)
// - copy sets zero flag from moved value, either destination
// - store writes working reg into file reg, flags untouched, one cycle
// - wake with global_irq_enable set branches to vector, else in-line
// - on such a wake the next instruction runs first, then the branch
// - wake needs the source enable only, not global_irq_enable
module mnie_exec (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [12:0] progCounter,
	output logic zeroFlag,
	output logic sleeping
);
	localparam int DW = mnie_pkg::DATA_W;
	localparam int AW = mnie_pkg::ADDR_W;

	// idle_op match: the two x bits are masked off before the compare
	function automatic logic isIdle(input logic [13:0] w);
		isIdle = (w & mnie_pkg::IDLE_MASK) == mnie_pkg::IDLE_CODE;
	endfunction : isIdle

	// copy_file_reg match on the top six bits
	function automatic logic isCopyOp(input logic [13:0] w);
		isCopyOp = w[13:8] == mnie_pkg::OP_COPY;
	endfunction : isCopyOp

	// store_working_reg match on the top seven bits
	function automatic logic isStoreOp(input logic [13:0] w);
		isStoreOp = w[13:7] == mnie_pkg::OP_STORE;
	endfunction : isStoreOp

	// next counter: the vector once a pending wake branch falls due
	function automatic logic [12:0] nextPc(input logic [12:0] pc,
		input logic vec);
		nextPc = vec ? mnie_pkg::IRQ_VECTOR : pc + 13'h0001;
	endfunction : nextPc

	// execution state: sleep machine, last word, working reg, zero flag
	mnie_pkg::mnie_state_t state_q, state_d;
	logic sleep_q, sleep_d;
	logic [13:0] instr_q, instr_d;
	logic [DW-1:0] work_q, work_d;
	logic zero_q, zero_d;
	// control bits, all written by software over the bus
	logic gie_q, gie_d, irqEn_q, irqEn_d, irqFlag_q, irqFlag_d;
	logic [12:0] pc_q, pc_d;
	// copy spends two extra cycles reading the file before it answers
	logic [1:0] phase_q, phase_d; // 0 idle, 1 read issued, 2 data ready
	logic pendVec_q, pendVec_d;
	// bus answer registers
	logic [31:0] rdata_q, rdata_d;
	logic wait_q, wait_d;
	// register file port: one address serves the write and the read
	logic memWe;
	logic [DW-1:0] memWData, memRData;
	logic [AW-1:0] memAddr;

	mnie_file_mem #(.DEPTH(128), .AW(AW), .DW(DW)) u_mem (
		.sys_clk(sys_clk),
		.we(memWe),
		.wAddr(memAddr),
		.wData(memWData),
		.rAddr(memAddr),
		.rData(memRData)
	);

	// decode and execute; copy needs a read cycle so the bus waits for it
	always_comb begin
		logic isCopy;
		logic isStore;
		logic isIdleOp;
		logic req;
		isCopy = 1'b0;
		isStore = 1'b0;
		isIdleOp = 1'b0;
		req = avs_read | avs_write;
		state_d = state_q;
		instr_d = instr_q;
		work_d = work_q;
		zero_d = zero_q;
		gie_d = gie_q;
		irqEn_d = irqEn_q;
		irqFlag_d = irqFlag_q;
		pc_d = pc_q;
		phase_d = phase_q;
		pendVec_d = pendVec_q;
		rdata_d = rdata_q;
		wait_d = 1'b1;
		memWe = 1'b0;
		memWData = work_q;
		memAddr = instr_q[AW-1:0];
		// decode the word on the bus; it is only acted on when taken
		isCopy = isCopyOp(avs_writedata[13:0]);
		isStore = isStoreOp(avs_writedata[13:0]);
		isIdleOp = isIdle(avs_writedata[13:0]);
		if (phase_q == 2'd1) begin
			phase_d = 2'd2;
		end else if (phase_q == 2'd2) begin
			// copy completes: pick destination, update zero
			if (instr_q[mnie_pkg::DEST_BIT]) begin
				memWe = 1'b1;
				memWData = memRData;
			end else begin
				work_d = memRData;
			end
			zero_d = memRData == '0;
			phase_d = 2'd0;
			wait_d = 1'b0;
			pc_d = nextPc(pc_q, pendVec_q);
			pendVec_d = 1'b0;
		end else if (req && wait_q) begin
			if (avs_write && avs_address == mnie_pkg::REG_INSTR) begin
				instr_d = avs_writedata[13:0];
				if (isCopy) begin
					phase_d = 2'd1;
				end else begin
					if (isStore) begin
						memWe = 1'b1;
						memAddr = avs_writedata[AW-1:0];
					end else if (isIdleOp) begin
						// idle_op: no register or flag touched
						memWe = 1'b0;
					end
					// codes outside this block still take a cycle, no effect
					wait_d = 1'b0;
					pc_d = nextPc(pc_q, pendVec_q);
					pendVec_d = 1'b0;
				end
			end else if (avs_write && avs_address == mnie_pkg::REG_CTRL) begin
				// one write replaces the GIE, IRQEN and IRQFLAG bits at once; a set SLEEP bit enters sleep, a clear one does not wake
				gie_d = avs_writedata[mnie_pkg::CTRL_GIE];
				irqEn_d = avs_writedata[mnie_pkg::CTRL_IRQEN];
				irqFlag_d = avs_writedata[mnie_pkg::CTRL_IRQFLAG];
				if (avs_writedata[mnie_pkg::CTRL_SLEEP]) begin
					state_d = mnie_pkg::MNIE_SLEEP;
				end
				wait_d = 1'b0;
			end else if (avs_write && avs_address == mnie_pkg::REG_WORK) begin
				work_d = avs_writedata[DW-1:0];
				wait_d = 1'b0;
			end else if (avs_read) begin
				// registered, so the data stand when waitrequest drops
				if (avs_address == mnie_pkg::REG_CTRL) begin
					rdata_d = {28'h0000000, irqFlag_q, state_q == mnie_pkg::MNIE_SLEEP,
						irqEn_q, gie_q};
				end else if (avs_address == mnie_pkg::REG_INSTR) begin
					rdata_d = {18'h00000, instr_q};
				end else if (avs_address == mnie_pkg::REG_STATUS) begin
					rdata_d = {18'h00000, pc_q, zero_q};
				end else if (avs_address == mnie_pkg::REG_WORK) begin
					rdata_d = {24'h000000, work_q};
				end else begin
					rdata_d = mnie_pkg::UNMAPPED;
				end
				wait_d = 1'b0;
			end else begin
				wait_d = 1'b0; // write to status: ignored
			end
		end
		// wake: only the source enable gates it
		if (state_q == mnie_pkg::MNIE_SLEEP && irqEn_q && irqFlag_q) begin
			state_d = mnie_pkg::MNIE_RUN;
			pendVec_d = gie_q; // vector after next instruction
		end
		// copy in flight holds the cycle; never end a read here
		if (phase_q != 2'd0 && phase_d != 2'd0) begin
			wait_d = 1'b1;
		end
		// sleep pin from its own flop, not decoded from the state
		sleep_d = state_d == mnie_pkg::MNIE_SLEEP;
	end

	// all state registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= mnie_pkg::MNIE_RUN;
			instr_q <= 14'h0000;
			work_q <= 8'h00;
			zero_q <= 1'b0;
			gie_q <= 1'b0;
			irqEn_q <= 1'b0;
			irqFlag_q <= 1'b0;
			pc_q <= mnie_pkg::PC_RESET;
			phase_q <= 2'd0;
			pendVec_q <= 1'b0;
			rdata_q <= 32'h00000000;
			wait_q <= 1'b1;
			sleep_q <= 1'b0;
		end else begin
			state_q <= state_d;
			instr_q <= instr_d;
			work_q <= work_d;
			zero_q <= zero_d;
			gie_q <= gie_d;
			irqEn_q <= irqEn_d;
			irqFlag_q <= irqFlag_d;
			pc_q <= pc_d;
			phase_q <= phase_d;
			pendVec_q <= pendVec_d;
			rdata_q <= rdata_d;
			wait_q <= wait_d;
			sleep_q <= sleep_d;
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;
	assign progCounter = pc_q;
	assign zeroFlag = zero_q;
	assign sleeping = sleep_q;
endmodule : mnie_exec

// ===== mnie_exec_properties.sv
/*
 Port assertions for mnie_exec.
 Assumes one clock and async active-high rst; bound after endmodule.
*/
module mnie_exec_properties (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] avs_address,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	input wire logic [12:0] progCounter,
	input wire logic zeroFlag,
	input wire logic sleeping
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic iReq;
	// instruction write still pending at the slave
	assign iReq = avs_write && avs_waitrequest && avs_address == 2'h1;
	property p_answer;
		avs_write && avs_waitrequest |-> ##[1:4] !avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer)
		else $error("write not answered");
	property p_pulse;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("answer longer than one cycle");
	property p_store;
		iReq && avs_writedata[13:7] == mnie_pkg::OP_STORE |=> $stable(zeroFlag);
	endproperty
	a_store: assert property (p_store)
		else $error("store touched zero flag");
	property p_idle;
		iReq && (avs_writedata[13:0] & mnie_pkg::IDLE_MASK) == 14'h0000
			|=> $stable(zeroFlag);
	endproperty
	a_idle: assert property (p_idle)
		else $error("idle touched zero flag");
	property p_zero;
		!$stable(zeroFlag) |-> $past(avs_write);
	endproperty
	a_zero: assert property (p_zero)
		else $error("zero flag moved without instruction");
	property p_step;
		!$stable(progCounter) |-> progCounter == $past(progCounter) + 13'h1
			|| progCounter == mnie_pkg::IRQ_VECTOR;
	endproperty
	a_step: assert property (p_step)
		else $error("bad counter step");
	property p_asleep;
		sleeping && $past(sleeping) |-> $stable(progCounter);
	endproperty
	a_asleep: assert property (p_asleep)
		else $error("counter moved in sleep");
	property p_wake;
		$fell(sleeping) |-> $past(avs_write) && $past(avs_address) == 2'h0;
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake without control write");
	c_sleep: cover property ($rose(sleeping));
	c_vector: cover property (progCounter == mnie_pkg::IRQ_VECTOR);
	c_zero: cover property ($rose(zeroFlag));
endmodule : mnie_exec_properties

bind mnie_exec mnie_exec_properties u_mnie_exec_properties (
	.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
	.avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_waitrequest(avs_waitrequest), .progCounter(progCounter),
	.zeroFlag(zeroFlag), .sleeping(sleeping));

// ===== testbench.sv
/*
 Bench for mnie_exec: bus tasks, instruction sequences, checks.
 Assumes the checker is bound from its own file.
*/
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] adr = 2'h0;
	logic rdEn = 1'b0;
	logic wrEn = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat, q;
	logic waitReq, zeroFlag, sleeping;
	logic [12:0] progCounter, pc;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	mnie_exec u_mnie_exec (.sys_clk(sys_clk), .rst(rst), .avs_address(adr),
		.avs_read(rdEn), .avs_write(wrEn), .avs_writedata(wd),
		.avs_readdata(rdat), .avs_waitrequest(waitReq),
		.progCounter(progCounter), .zeroFlag(zeroFlag), .sleeping(sleeping));
	initial forever #5 sys_clk = ~sys_clk;
	// ceiling far above the hundred or so cycles the tests need
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	// hold request until waitrequest seen low, settle before checks
	task automatic acc(input logic w, input logic [1:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		adr <= a;
		wd <= d;
		wrEn <= w;
		rdEn <= ~w;
		do @(posedge sys_clk); while (waitReq !== 1'b0);
		q = rdat;
		wrEn <= 1'b0;
		rdEn <= 1'b0;
		@(negedge sys_clk);
	endtask : acc
	task automatic ex(input logic [13:0] i);
		acc(1'b1, 2'h1, {18'h0, i});
		pc = pc + 13'h1;
	endtask : ex
	task automatic cs(input logic z, input logic [7:0] w);
		chk(32'(zeroFlag), 32'(z));
		chk(32'(progCounter), 32'(pc));
		acc(1'b0, 2'h3, 32'h0);
		chk(q, 32'(w));
	endtask : cs
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		pc = mnie_pkg::PC_RESET;
		acc(1'b1, 2'h3, 32'h5a);
		ex(14'h00ff);
		cs(1'b0, 8'h5a);
		acc(1'b1, 2'h3, 32'h0);
		ex(14'h0080);
		acc(1'b1, 2'h3, 32'h33);
		ex(14'h0880);
		cs(1'b1, 8'h33);
		for (int i = 0; i < 4; i++) ex({7'h0, 2'(i), 5'h0});
		cs(1'b1, 8'h33);
		// store while zero is set: the flag must survive
		ex(14'h0081);
		cs(1'b1, 8'h33);
		// d=1 on a non-zero register clears zero and leaves W alone
		ex(14'h08ff);
		cs(1'b0, 8'h33);
		ex(14'h087f);
		cs(1'b0, 8'h5a);
		ex(14'h0801);
		cs(1'b0, 8'h33);
		acc(1'b1, 2'h2, 32'h3fff);
		acc(1'b0, 2'h2, 32'h0);
		chk(q, {18'h0, pc, 1'b0});
		acc(1'b1, 2'h0, 32'h6);
		acc(1'b1, 2'h0, 32'h8);
		chk(32'(sleeping), 32'h1);
		acc(1'b1, 2'h0, 32'ha);
		chk(32'(sleeping), 32'h0);
		ex(14'h0000);
		chk(32'(progCounter), 32'(pc));
		acc(1'b1, 2'h0, 32'h7);
		acc(1'b1, 2'h3, 32'h0);
		acc(1'b1, 2'h0, 32'hb);
		chk(32'(sleeping), 32'h0);
		ex(14'h087f);
		pc = mnie_pkg::IRQ_VECTOR;
		cs(1'b0, 8'h5a);
		ex(14'h0000);
		chk(32'(progCounter), 32'(pc));
		end_sim();
	end
endmodule : testbench
